// >>> rtl/usb_endpoint_transaction_ctrl.sv
// endpoint transaction controller: flags, fifos, token handling
//
// Local design decisions: the strobed register port and the register offsets.
module usb_endpoint_transaction_ctrl
  import usb_ep_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // tokens and received data from the serial engine
  input  wire logic       tok_valid,
  input  pid_t            tok_pid,
  input  wire logic [1:0] tok_ep,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_end,
  input  wire logic       rx_crc_ok,
  // transmit data and handshakes to the serial engine
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  output logic            tx_last,
  output logic            tx_zlp,
  input  wire logic       tx_ready,
  input  wire logic       host_ack,
  output logic            hs_valid,
  output hs_t             hs_code,
  // interrupt request
  output logic            usb_irq
);
  logic [1:0]        sel_q;
  logic [NUM_EP-1:0] txr_q, txc_q, rx0_q, crc_q, ien_q, ep_flag;
  logic              setup_q, dir_q;
  logic [1:0]        rdy_pp_q, cmpl_pp_q;
  logic              fw_bank_q, sie_bank_q, cmpl_bank_q;
  logic [CW-1:0]     bcnt_q [NUM_EP];
  logic [2:0]        cfg_q [NUM_EP];
  logic [7:0]        rdata_q, sta_view;
  logic              irq_q, hs_valid_q;
  hs_t               hs_code_q;
  sie_state_t        st_q;
  pid_t              cur_pid_q;
  logic [1:0]        cur_ep_q, cur_bank_q, fwb, tok_bank;
  logic              nak_q, cur_iso, tok_iso, store_en;
  logic [CW-1:0]     rcnt_q;
  logic              wr_sta, fw_set_pp, fw_clr_pp;
  logic              ev_txdone, ev_rx_end, ev_setup, ev_rx_ok, ev_iso, tx_go;
  logic [NUM_BANK-1:0] wr_en_v, rd_en_v, clr_v, rew_v;
  logic [7:0]        wr_data;
  logic [7:0]        b_rdat [NUM_BANK];
  logic [PW-1:0]     b_cnt [NUM_BANK];
  logic [PW-1:0]     b_rptr [NUM_BANK];

  ////////////////////////////////////////////////////////////////////////////
  // fifo banks: 0 control, 1 standard, 2 and 3 the ping-pong pair
  fifo_if f [NUM_BANK] ();
  for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
    assign f[b].wr_en   = wr_en_v[b];
    assign f[b].wr_data = wr_data;
    assign f[b].rd_en   = rd_en_v[b];
    assign f[b].clr     = clr_v[b];
    assign f[b].rewind  = rew_v[b];
    assign b_rdat[b]    = f[b].rd_data;
    assign b_cnt[b]     = f[b].cnt;
    assign b_rptr[b]    = f[b].rptr;
    ep_fifo #(.DEPTH((b < 2) ? DEPTH_SMALL : DEPTH_PP)) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .p    (f[b])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of firmware accesses and serial-engine events
  assign wr_sta    = reg_wr && reg_addr == ADDR_STA;
  assign fwb       = (sel_q == EP_PP) ? {1'b1, fw_bank_q} : sel_q;
  assign tok_bank  = (tok_ep == EP_PP) ? {1'b1, sie_bank_q} : tok_ep;
  assign fw_set_pp = wr_sta && sel_q == EP_PP && reg_wdata[B_TXR] && !rdy_pp_q[fw_bank_q];
  assign fw_clr_pp = wr_sta && sel_q == EP_PP && !reg_wdata[B_TXC] && cmpl_pp_q[cmpl_bank_q];
  assign cur_iso   = cfg_q[cur_ep_q][1:0] == TYPE_ISO;
  assign tok_iso   = cfg_q[tok_ep][1:0] == TYPE_ISO;
  // iso stores only while the receive flag is clear, so a clear mid-packet
  // keeps just the bytes that follow it
  assign store_en  = cur_pid_q == PID_SETUP || (!nak_q && !(cur_iso && rx0_q[cur_ep_q]));
  assign ev_txdone = st_q == S_ACKWAIT && (host_ack || cur_iso);
  assign ev_rx_end = st_q == S_RX && rx_end;
  assign ev_setup  = ev_rx_end && cur_pid_q == PID_SETUP && rx_crc_ok;
  assign ev_rx_ok  = ev_rx_end && cur_pid_q == PID_OUT && !cur_iso && !nak_q && rx_crc_ok;
  // iso packet counts whenever the receive flag was free by the end
  assign ev_iso    = ev_rx_end && cur_pid_q == PID_OUT && cur_iso && !rx0_q[cur_ep_q];
  assign tx_go     = tx_valid && tx_ready;

  // transmit stream: zero-length when nothing was written
  assign tx_valid = st_q == S_TX;
  assign tx_data  = b_rdat[cur_bank_q];
  assign tx_zlp   = b_cnt[cur_bank_q] == '0;
  assign tx_last  = tx_zlp || (b_rptr[cur_bank_q] + 7'h01) >= b_cnt[cur_bank_q];

  ////////////////////////////////////////////////////////////////////////////
  // fifo strobes; the serial engine's byte wins over a firmware write
  always_comb begin
    wr_en_v = '0;
    rd_en_v = '0;
    clr_v   = '0;
    rew_v   = '0;
    wr_data = reg_wdata;
    if (reg_wr && reg_addr == ADDR_DAT) begin
      wr_en_v[fwb] = 1'b1;
    end
    if (reg_rd && reg_addr == ADDR_DAT) begin
      rd_en_v[fwb] = 1'b1;
    end
    if (st_q == S_RX && rx_valid && store_en) begin
      wr_en_v          = '0;
      wr_en_v[cur_bank_q] = 1'b1;
      wr_data          = rx_data;
    end
    if (tx_go) begin
      rd_en_v[cur_bank_q] = 1'b1;
    end
    if (ev_txdone) begin
      clr_v[cur_bank_q] = 1'b1;
    end else if (st_q == S_ACKWAIT && tok_valid) begin
      rew_v[cur_bank_q] = 1'b1; // no ack: replay the same packet
    end
    if (st_q == S_IDLE && tok_valid && tok_pid == PID_SETUP && tok_ep == EP_CTRL) begin
      clr_v[EP_CTRL] = 1'b1;
    end
    if (wr_sta && sel_q != EP_PP) begin
      if (txr_q[sel_q] && !reg_wdata[B_TXR]) clr_v[sel_q] = 1'b1;
      if (rx0_q[sel_q] && !reg_wdata[B_RX0]) clr_v[sel_q] = 1'b1;
      if (sel_q == EP_CTRL && setup_q && !reg_wdata[B_SETUP]) clr_v[EP_CTRL] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select, configuration and interrupt enable registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_q <= '0;
      ien_q <= '0;
      for (int e = 0; e < NUM_EP; e++) cfg_q[e] <= CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_SEL && reg_wdata[1:0] < 2'(NUM_EP)) sel_q <= reg_wdata[1:0];
      if (reg_addr == ADDR_IEN) ien_q <= reg_wdata[NUM_EP-1:0];
      if (reg_addr == ADDR_CFG && sel_q != EP_CTRL) cfg_q[sel_q] <= reg_wdata[2:0];
    end
  end

  // standard endpoint flags: a hardware set beats a firmware clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      txr_q <= '0;
      txc_q <= '0;
      rx0_q <= '0;
      crc_q <= '0;
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        if (wr_sta && sel_q == e) begin
          txr_q[e] <= reg_wdata[B_TXR] && e != EP_PP;
          if (!reg_wdata[B_TXC]) txc_q[e] <= 1'b0;
          if (!reg_wdata[B_RX0]) rx0_q[e] <= 1'b0;
          if (!reg_wdata[B_CRC]) crc_q[e] <= 1'b0;
        end else if (ev_txdone && cur_ep_q == e) begin
          txr_q[e] <= 1'b0;
        end
        if (ev_setup && e == EP_CTRL) begin
          txr_q[e] <= 1'b0;
          txc_q[e] <= 1'b0;
          rx0_q[e] <= 1'b0;
          crc_q[e] <= 1'b0;
        end
        if (ev_txdone && cur_ep_q == e && e != EP_PP) txc_q[e] <= 1'b1;
        if ((ev_rx_ok || ev_iso) && cur_ep_q == e) rx0_q[e] <= 1'b1;
        if (ev_iso && cur_ep_q == e) crc_q[e] <= !rx_crc_ok;
      end
    end
  end

  // control endpoint setup flag and direction bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      setup_q <= 1'b0;
      dir_q   <= 1'b0;
    end else if (ev_setup) begin
      setup_q <= 1'b1;
      dir_q   <= 1'b0;
    end else if (wr_sta && sel_q == EP_CTRL) begin
      if (!reg_wdata[B_SETUP]) setup_q <= 1'b0;
      dir_q <= reg_wdata[B_DIR];
    end
  end

  // ping-pong banks: ready flips the firmware bank, completions are
  // reported bank by bank and each clear moves to the other bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdy_pp_q    <= '0;
      cmpl_pp_q   <= '0;
      fw_bank_q   <= 1'b0;
      sie_bank_q  <= 1'b0;
      cmpl_bank_q <= 1'b0;
    end else begin
      if (fw_clr_pp) begin
        cmpl_pp_q[cmpl_bank_q] <= 1'b0;
        cmpl_bank_q            <= !cmpl_bank_q;
      end
      if (ev_txdone && cur_ep_q == EP_PP) begin
        rdy_pp_q[cur_bank_q[0]]  <= 1'b0;
        cmpl_pp_q[cur_bank_q[0]] <= 1'b1;
        sie_bank_q               <= !sie_bank_q;
      end
      if (fw_set_pp) begin
        rdy_pp_q[fw_bank_q] <= 1'b1;
        fw_bank_q           <= !fw_bank_q;
      end
    end
  end

  // byte counters load with each accepted packet
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int e = 0; e < NUM_EP; e++) bcnt_q[e] <= '0;
    end else if (ev_setup || ev_rx_ok || ev_iso) begin
      bcnt_q[cur_ep_q] <= rcnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q       <= S_IDLE;
      cur_pid_q  <= PID_IN;
      cur_ep_q   <= '0;
      cur_bank_q <= '0;
      nak_q      <= 1'b0;
      rcnt_q     <= '0;
      hs_valid_q <= 1'b0;
      hs_code_q  <= HS_ACK;
    end else begin
      hs_valid_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (tok_valid) begin
            cur_pid_q  <= tok_pid;
            cur_ep_q   <= tok_ep;
            cur_bank_q <= tok_bank;
            rcnt_q     <= '0;
            nak_q      <= 1'b0;
            if (tok_pid == PID_IN) begin
              if (tok_ep == EP_PP ? rdy_pp_q[sie_bank_q] : txr_q[tok_ep]) begin
                st_q <= S_TX;
              end else if (!tok_iso) begin
                hs_valid_q <= 1'b1;
                hs_code_q  <= HS_NAK;
              end
            end else if (tok_pid == PID_SETUP) begin
              if (tok_ep == EP_CTRL) st_q <= S_RX;
            end else if (tok_ep != EP_PP) begin
              st_q  <= S_RX;
              nak_q <= rx0_q[tok_ep] && !tok_iso;
            end
          end
        end
        S_TX: begin
          if (tx_go && tx_last) st_q <= S_ACKWAIT;
        end
        S_ACKWAIT: begin
          if (ev_txdone || tok_valid) st_q <= S_IDLE;
        end
        S_RX: begin
          if (rx_valid && store_en) begin
            rcnt_q <= rcnt_q + 10'h001;
          end
          if (rx_end) begin
            st_q <= S_IDLE;
            // iso never answers; bad crc gets no answer unless nak_q refuses the packet with a NAK
            if (!cur_iso && (nak_q || rx_crc_ok)) begin
              hs_valid_q <= 1'b1;
              hs_code_q  <= nak_q ? HS_NAK : HS_ACK;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign hs_valid = hs_valid_q;
  assign hs_code  = hs_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux and interrupt
  always_comb begin
    sta_view        = '0;
    sta_view[B_TXC] = txc_q[sel_q];
    sta_view[B_RX0] = rx0_q[sel_q];
    sta_view[B_CRC] = crc_q[sel_q];
    sta_view[B_TXR] = txr_q[sel_q];
    if (sel_q == EP_CTRL) begin
      sta_view[B_SETUP] = setup_q;
      sta_view[B_DIR]   = dir_q;
    end
    if (sel_q == EP_PP) begin
      sta_view[B_TXC] = |cmpl_pp_q;
      sta_view[B_TXR] = rdy_pp_q[fw_bank_q];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_SEL: rdata_q <= {6'h00, sel_q};
        ADDR_STA: rdata_q <= sta_view;
        ADDR_CFG: rdata_q <= {5'h00, cfg_q[sel_q]};
        ADDR_DAT: rdata_q <= b_rdat[fwb];
        ADDR_BCL: rdata_q <= bcnt_q[sel_q][7:0];
        ADDR_BCH: rdata_q <= {6'h00, bcnt_q[sel_q][CW-1:8]};
        ADDR_IEN: rdata_q <= {5'h00, ien_q};
        default:  rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // level interrupt: held while any enabled endpoint has a flag up
  assign ep_flag = txc_q | rx0_q | crc_q | {|cmpl_pp_q, 1'b0, setup_q};
  always_ff @(posedge mclk) begin
    if (rst) irq_q <= 1'b0;
    else     irq_q <= |(ien_q & ep_flag);
  end
  assign usb_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_nak_not_ready: assert property (
    st_q == S_IDLE && tok_valid && tok_pid == PID_IN && tok_ep == 2'h1 && !txr_q[1]
    && cfg_q[1][1:0] != TYPE_ISO |=> hs_valid && hs_code == HS_NAK)
    else $error("IN without ready was not refused");
  a_zlp_when_empty: assert property (
    st_q == S_IDLE && tok_valid && tok_pid == PID_IN && tok_ep == 2'h1 && txr_q[1]
    && b_cnt[1] == '0 |=> tx_valid && tx_zlp && tx_last)
    else $error("empty ready fifo did not send a zero-length packet");
  a_ack_completes: assert property (
    st_q == S_ACKWAIT && host_ack && cur_ep_q == 2'h1 |=> txc_q[1] && !txr_q[1] ##1 usb_irq
    || !ien_q[1])
    else $error("acknowledged packet did not complete");
  a_cancel_flushes: assert property (
    wr_sta && sel_q == 2'h1 && txr_q[1] && !reg_wdata[B_TXR] |=> b_cnt[1] == '0)
    else $error("cancelled packet left in fifo");
  a_setup_clears: assert property (
    ev_setup |=> setup_q && !rx0_q[0] && !txr_q[0] && !txc_q[0] && !dir_q)
    else $error("setup did not reset endpoint status");
  a_pp_bank_flip: assert property (
    fw_set_pp |=> fw_bank_q != $past(fw_bank_q) && rdy_pp_q[$past(fw_bank_q)])
    else $error("ready set did not switch bank");
  a_iso_silent: assert property (
    ev_rx_end && cur_iso |=> !hs_valid)
    else $error("iso transaction got a handshake");
  a_crc_tracks: assert property (
    ev_iso |=> crc_q[$past(cur_ep_q)] == !$past(rx_crc_ok) && rx0_q[$past(cur_ep_q)])
    else $error("iso crc flag not updated");
  a_irq_level: assert property (
    |(ien_q & ep_flag) |=> usb_irq)
    else $error("interrupt missing while enabled flag set");
endmodule : usb_endpoint_transaction_ctrl

// >>> rtl/usb_ep_pkg.sv
// shared constants and types of the endpoint transaction controller
package usb_ep_pkg;
  localparam int NUM_EP   = 3;
  localparam int NUM_BANK = 4;
  localparam int AW       = 6;
  localparam int CW       = 10;
  localparam int PW       = 7;
  // per-bank fifo capacity in bytes
  localparam logic [PW-1:0] DEPTH_SMALL = 7'h20;
  localparam logic [PW-1:0] DEPTH_PP    = 7'h40;
  // endpoint numbers with a fixed role
  localparam logic [1:0] EP_CTRL = 2'h0;
  localparam logic [1:0] EP_PP   = 2'h2;
  // register port offsets
  localparam logic [2:0] ADDR_SEL = 3'h0;
  localparam logic [2:0] ADDR_STA = 3'h1;
  localparam logic [2:0] ADDR_CFG = 3'h2;
  localparam logic [2:0] ADDR_DAT = 3'h3;
  localparam logic [2:0] ADDR_BCL = 3'h4;
  localparam logic [2:0] ADDR_BCH = 3'h5;
  localparam logic [2:0] ADDR_IEN = 3'h6;
  // endpoint_status_reg bit positions
  localparam int B_TXC   = 0;
  localparam int B_RX0   = 1;
  localparam int B_SETUP = 2;
  localparam int B_CRC   = 3;
  localparam int B_TXR   = 4;
  localparam int B_DIR   = 7;
  // configuration register: type in [1:0], direction in [2]
  localparam int B_EPDIR = 2;
  localparam logic [1:0] TYPE_CTRL = 2'h0;
  localparam logic [1:0] TYPE_ISO  = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  typedef enum logic [1:0] {PID_IN, PID_OUT, PID_SETUP} pid_t;
  typedef enum logic {HS_ACK, HS_NAK} hs_t;
  typedef enum logic [1:0] {S_IDLE, S_TX, S_ACKWAIT, S_RX} sie_state_t;
endpackage : usb_ep_pkg

// >>> rtl/fifo_if.sv
// bundle between the controller and one fifo bank
interface fifo_if;
  import usb_ep_pkg::*;
  logic          wr_en;
  logic [7:0]    wr_data;
  logic          rd_en;
  logic          clr;
  logic          rewind;
  logic [7:0]    rd_data;
  logic [PW-1:0] cnt;
  logic [PW-1:0] rptr;
  modport ctrl (output wr_en, wr_data, rd_en, clr, rewind, input rd_data, cnt, rptr);
  modport mem  (input wr_en, wr_data, rd_en, clr, rewind, output rd_data, cnt, rptr);
endinterface : fifo_if

// >>> rtl/ep_fifo.sv
// one endpoint fifo bank in flip-flops with write count and read pointer
module ep_fifo
  import usb_ep_pkg::*;
#(
  parameter logic [PW-1:0] DEPTH = DEPTH_SMALL
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // controller side
  fifo_if.mem      p
);
  logic [7:0]    mem_q [2**AW];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;

  ////////////////////////////////////////////////////////////////////////////
  // write side: bytes past capacity are dropped, the count never wraps
  always_ff @(posedge mclk) begin
    if (rst || p.clr) begin
      wptr_q <= '0;
    end else if (p.wr_en && wptr_q < DEPTH) begin
      mem_q[wptr_q[AW-1:0]] <= p.wr_data;
      wptr_q <= wptr_q + 7'h01;
    end
  end

  // read side: rewind lets a failed transmission be replayed
  always_ff @(posedge mclk) begin
    if (rst || p.clr || p.rewind) begin
      rptr_q <= '0;
    end else if (p.rd_en && rptr_q < wptr_q) begin
      rptr_q <= rptr_q + 7'h01;
    end
  end

  assign p.rd_data = mem_q[rptr_q[AW-1:0]];
  assign p.cnt     = wptr_q;
  assign p.rptr    = rptr_q;

  a_fifo_capacity: assert property (@(posedge mclk) disable iff (rst) wptr_q <= DEPTH)
    else $error("fifo count above capacity");
endmodule : ep_fifo

// >>> tb/usb_host_model.sv
// usb host model: issues tokens, sends data packets, takes and acknowledges in packets
module usb_host_model
  import usb_ep_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // tokens and out data
  output logic            tok_valid,
  output pid_t            tok_pid,
  output logic      [1:0] tok_ep,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  output logic            rx_crc_ok,
  // in data
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            host_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tok_valid = 1'b0;
    tok_pid   = PID_IN;
    tok_ep    = 2'h0;
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_end    = 1'b0;
    rx_crc_ok = 1'b0;
    tx_ready  = 1'b0;
    host_ack  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ready toggles so the engine meets a stalling host as well as a prompt one
  always @(posedge mclk) begin
    tx_ready <= ~tx_ready;
    host_ack <= tx_valid && tx_ready && tx_last;
  end

  // one-cycle token, then tok_ep no longer holds its value
  task automatic token(input pid_t p, input logic [1:0] e);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_pid   <= p;
    tok_ep    <= e;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_ep    <= ~e;
  endtask : token

  // token, n data bytes, then end of packet with its crc verdict
  task automatic packet(input pid_t p, input logic [1:0] e, input logic [7:0] d[8],
                        input int n, input logic ok);
    token(p, e);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data  <= d[i];
    end
    @(posedge mclk);
    rx_valid  <= 1'b0;
    rx_data   <= ~rx_data;
    rx_end    <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge mclk);
    rx_end    <= 1'b0;
    rx_crc_ok <= ~ok;
  endtask : packet
endmodule : usb_host_model

// >>> tb/testbench.sv
// self-checking testbench of the endpoint transaction controller
module testbench
  import usb_ep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string name; logic [7:0] val;} note_t;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, rx_data, tx_data;
  logic       tok_valid, rx_valid, rx_end, rx_crc_ok, tx_valid, tx_last, tx_zlp;
  logic       tx_ready, host_ack, hs_valid, usb_irq, rd_q;
  pid_t       tok_pid;
  hs_t        hs_code;
  logic [1:0] tok_ep;
  logic [7:0] d[8];
  note_t      q[$];
  note_t      e;
  int         num_errors = 0;
  int         n_tests = 0;
  int         seed = 55569;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  usb_endpoint_transaction_ctrl dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_zlp(tx_zlp), .tx_ready(tx_ready),
    .host_ack(host_ack), .hs_valid(hs_valid), .hs_code(hs_code), .usb_irq(usb_irq));

  usb_host_model host_u (.mclk(mclk), .tok_valid(tok_valid), .tok_pid(tok_pid),
    .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .host_ack(host_ack));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // compare a result that appeared against the oldest note
  task automatic take(input logic [7:0] g);
    if (q.size() == 0) begin
      num_errors++;
      $display("CHECK FAILED unexpected result expected none seen %h", g);
    end else begin
      e = q.pop_front();
      chk(e.name, e.val, g);
    end
  endtask : take

  function automatic void note(input string n, input logic [7:0] v);
    q.push_back('{n, v});
  endfunction : note

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] x, input string n);
    note(n, x);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
  endtask : rd

  // bounded wait until every noted result has shown up
  task automatic settle();
    for (int i = 0; i < 300 && q.size() > 0; i++) begin
      @(posedge mclk);
    end
    repeat (5) @(posedge mclk);
    if (q.size() > 0) begin
      num_errors++;
      $display("CHECK FAILED wait expected 0 seen %0d", q.size());
      conclude();
    end
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: read data one cycle after the strobe, handshakes, accepted tx beats
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) take(reg_rdata);
    if (hs_valid === 1'b1) take({7'h00, hs_code});
    if (tx_valid === 1'b1 && tx_ready === 1'b1) take(tx_zlp ? 8'hff : tx_data);
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_STA, 8'h00, "status_after_reset");
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_SEL, 8'h01);
    note("nak_not_ready", HS_NAK);
    host_u.token(PID_IN, 2'h1);
    settle();
    for (int i = 0; i < 2; i++) begin
      d[i] = 8'($random(seed));
      wr(ADDR_DAT, d[i]);
    end
    // the count read answers before any in byte, so its note goes first
    rd(ADDR_BCL, 8'h00, "count_after_fill");
    for (int i = 0; i < 2; i++) note("in_byte", d[i]);
    wr(ADDR_STA, 8'h10);
    host_u.token(PID_IN, 2'h1);
    settle();
    rd(ADDR_STA, 8'h01, "complete_after_ack");
    settle();
    chk("irq_level", 8'h01, {7'h00, usb_irq});
    wr(ADDR_STA, 8'h00);
    // cancelled packet must vanish, so the next ready sends nothing
    wr(ADDR_DAT, 8'h5a);
    wr(ADDR_STA, 8'h10);
    wr(ADDR_STA, 8'h00);
    wr(ADDR_STA, 8'h10);
    note("zero_length", 8'hff);
    host_u.token(PID_IN, 2'h1);
    settle();
    wr(ADDR_STA, 8'h00);
    wr(ADDR_SEL, 8'h00);
    for (int i = 0; i < 8; i++) d[i] = 8'($random(seed));
    note("setup_ack", HS_ACK);
    host_u.packet(PID_SETUP, 2'h0, d, 8, 1'b1);
    settle();
    rd(ADDR_STA, 8'h04, "setup_status");
    rd(ADDR_BCL, 8'h08, "setup_count");
    for (int i = 0; i < 8; i++) rd(ADDR_DAT, d[i], "setup_byte");
    wr(ADDR_STA, 8'h00);
    // control read: direction first, then data, then ready
    wr(ADDR_STA, 8'h80);
    wr(ADDR_DAT, d[1]);
    wr(ADDR_STA, 8'h90);
    note("ctrl_in_byte", d[1]);
    host_u.token(PID_IN, 2'h0);
    settle();
    rd(ADDR_STA, 8'h81, "ctrl_in_status");
    // status stage: zero-length IN with the direction back at 0
    wr(ADDR_STA, 8'h00);
    wr(ADDR_STA, 8'h10);
    note("ctrl_status_zlp", 8'hff);
    host_u.token(PID_IN, 2'h0);
    settle();
    wr(ADDR_STA, 8'h00);
    // out data stage: receive flag and count, then NAK while the flag stays up
    note("out_ack", HS_ACK);
    host_u.packet(PID_OUT, 2'h0, d, 4, 1'b1);
    settle();
    rd(ADDR_STA, 8'h02, "out_status");
    note("out_nak", HS_NAK);
    host_u.packet(PID_OUT, 2'h0, d, 2, 1'b1);
    settle();
    rd(ADDR_BCL, 8'h04, "out_count");
    rd(ADDR_DAT, d[0], "out_byte");
    wr(ADDR_STA, 8'h00);
    // isochronous out on endpoint 1: no handshakes at all
    wr(ADDR_SEL, 8'h01);
    wr(ADDR_CFG, {6'h00, TYPE_ISO});
    host_u.packet(PID_OUT, 2'h1, d, 3, 1'b1);
    settle();
    rd(ADDR_STA, 8'h02, "iso_status");
    rd(ADDR_BCL, 8'h03, "iso_count");
    host_u.packet(PID_OUT, 2'h1, d, 5, 1'b1);
    settle();
    rd(ADDR_BCL, 8'h03, "iso_dropped");
    wr(ADDR_STA, 8'h00);
    host_u.packet(PID_OUT, 2'h1, d, 2, 1'b0);
    settle();
    rd(ADDR_STA, 8'h0a, "iso_crc");
    // ping-pong endpoint
    wr(ADDR_SEL, 8'h02);
    wr(ADDR_CFG, 8'h06);
    note("nak_bank", HS_NAK);
    host_u.token(PID_IN, 2'h2);
    settle();
    wr(ADDR_DAT, 8'h33);
    wr(ADDR_STA, 8'h10);
    rd(ADDR_STA, 8'h00, "bank_switched");
    note("pp_byte", 8'h33);
    host_u.token(PID_IN, 2'h2);
    settle();
    rd(ADDR_STA, 8'h01, "bank0_complete");
    settle();
    conclude();
  end
endmodule : testbench
